// ==== verilog/hcsc_pkg.sv ====
`default_nettype none
package hcsc_pkg;
    // Clock and bus-reset timing
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned BUS_RST_MIN_MS  = 1900;
    localparam int unsigned BUS_RST_CYC     = (CLK_HZ / 1000) * BUS_RST_MIN_MS;
    localparam int unsigned BUS_RST_CNT_W   = 26;

    // Command address map (7-bit)
    localparam logic [6:0] CMD_STATUS       = 7'h00;
    localparam logic [6:0] CMD_ALERT        = 7'h01;
    localparam logic [6:0] CMD_ALERT_MASK   = 7'h02;
    localparam logic [6:0] CMD_SUB_LO       = 7'h3E;
    localparam logic [6:0] CMD_SUB_HI       = 7'h3F;
    localparam logic [6:0] CMD_BLOCK        = 7'h40;

    // Subcommand codes
    localparam logic [15:0] SC_LOCK         = 16'h0010;
    localparam logic [15:0] SC_CFG_ENTER    = 16'h0011;
    localparam logic [15:0] SC_CFG_EXIT     = 16'h0012;
    localparam logic [15:0] SC_BLK_READ     = 16'h0020;
    localparam logic [15:0] SC_BLK_WRITE    = 16'h0021;

    // Power modes
    localparam logic [1:0] PM_NORMAL        = 2'h0;
    localparam logic [1:0] PM_SLEEP         = 2'h1;
    localparam logic [1:0] PM_DEEP          = 2'h2;
    localparam logic [1:0] PM_SHUTDOWN      = 2'h3;

    // Status and alert bit positions
    localparam int ST_UNLOCKED = 0;
    localparam int ST_CFG      = 1;
    localparam int ST_LOADING  = 2;
    localparam int ST_RUNNING  = 3;
    localparam int AL_UNLOCK   = 0;
    localparam int AL_CFG_IN   = 1;
    localparam int AL_CFG_OUT  = 2;
    localparam int AL_REJECT   = 3;
    localparam int AL_BUS_RST  = 4;
    localparam int AL_LOADED   = 5;

    // Setting indexes and fields
    localparam int SET_REG_IDX  = 0;
    localparam int SET_PROT_IDX = 1;
    localparam int SET_OSC_IDX  = 2;
    localparam logic [2:0] REG_SEL_MAX   = 3'h4;
    localparam logic [2:0] REG_SEL_RST   = 3'h0;
    localparam logic [7:0] ALERT_MASK_RST = 8'hFF;

    typedef enum logic [2:0] {
        SUB_NONE, SUB_KEY1, SUB_KEY2, SUB_LOCK,
        SUB_CFG_ENTER, SUB_CFG_EXIT, SUB_BLK_READ, SUB_BLK_WRITE
    } sub_t;

    typedef enum logic [1:0] {ST_OFF, ST_LOAD, ST_RUN, ST_CFGUPD} state_t;
endpackage
`default_nettype wire

// ==== verilog/host_command_security_config.sv ====
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module host_command_security_config
    import hcsc_pkg::*;
#(
    parameter int          N_SET       = 16,
    parameter int          RUNTIME_SET = 4,
    parameter int unsigned BUS_RST_LIM = BUS_RST_CYC,
    parameter logic [15:0] KEY1        = 16'h1A2B, // arbitrary value
    parameter logic [15:0] KEY2        = 16'h3C4D, // arbitrary value
    parameter int          AW          = $clog2(N_SET)
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic [6:0]    i_addr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output var  logic [7:0]    o_rdata,
    input  wire logic [1:0]    i_pwr_mode,
    input  wire logic          i_scl,
    input  wire logic [7:0]    i_otp_data,
    output var  logic [AW-1:0] o_otp_addr,
    output var  logic          o_otp_rd,
    output var  logic          o_alert_n,
    output var  logic          o_unlocked,
    output var  logic          o_cfg_update,
    output var  logic          o_running,
    output var  logic [2:0]    o_reg_sel,
    output var  logic [7:0]    o_prot_host,
    output var  logic          o_osc_low_speed,
    output var  logic          o_bus_rst
);
    // Block window decode, used by read and write paths
    function automatic logic is_blk(input logic [6:0] a);
        is_blk = (int'(a) >= int'(CMD_BLOCK)) &&
                 (int'(a) < int'(CMD_BLOCK) + N_SET);
    endfunction

    // Subcommand decode
    function automatic sub_t sub_decode(input logic [15:0] c);
        if (c == KEY1) begin
            sub_decode = SUB_KEY1;
        end else if (c == KEY2) begin
            sub_decode = SUB_KEY2;
        end else if (c == SC_LOCK) begin
            sub_decode = SUB_LOCK;
        end else if (c == SC_CFG_ENTER) begin
            sub_decode = SUB_CFG_ENTER;
        end else if (c == SC_CFG_EXIT) begin
            sub_decode = SUB_CFG_EXIT;
        end else if (c == SC_BLK_READ) begin
            sub_decode = SUB_BLK_READ;
        end else if (c == SC_BLK_WRITE) begin
            sub_decode = SUB_BLK_WRITE;
        end else begin
            sub_decode = SUB_NONE;
        end
    endfunction

    state_t               state_r, state_nxt;
    logic [7:0]           cfg_r [N_SET];
    logic [7:0]           cfg_nxt [N_SET];
    logic [7:0]           blk_r [N_SET];
    logic [7:0]           blk_nxt [N_SET];
    logic [AW:0]          ld_cnt_r, ld_cnt_nxt;
    logic                 unlocked_r, unlocked_nxt;
    logic                 key1_r, key1_nxt;
    logic [7:0]           sub_lo_r, sub_lo_nxt;
    logic [7:0]           alert_r, alert_nxt;
    logic [7:0]           mask_r, mask_nxt;
    logic [7:0]           rdata_nxt;
    logic [7:0]           alert_set, alert_clr;
    logic [2:0]           reg_sel_nxt;
    logic [7:0]           prot_nxt;
    logic                 osc_nxt;
    logic                 live;
    sub_t                 sub;
    logic [2:0]           scl_sync_r;
    logic                 scl_low_r, scl_low_nxt;
    logic [BUS_RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
    logic                 bus_rst_nxt;

    // SCL sampler: 20 MHz easily oversamples a 400 kHz bus
    always_comb begin
        scl_low_nxt = scl_low_r;
        if (!scl_sync_r[1] && !scl_sync_r[2]) begin
            scl_low_nxt = 1'b1;
        end else if (scl_sync_r[1] && scl_sync_r[2]) begin
            scl_low_nxt = 1'b0;
        end
        rst_cnt_nxt = '0;
        bus_rst_nxt = 1'b0;
        if (scl_low_r) begin
            if (rst_cnt_r == BUS_RST_CNT_W'(BUS_RST_LIM - 1)) begin
                bus_rst_nxt = 1'b1;
                rst_cnt_nxt = '0;
            end else begin
                rst_cnt_nxt = rst_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_sync_r <= 3'h7;
            scl_low_r  <= 1'b0;
            rst_cnt_r  <= '0;
            o_bus_rst  <= 1'b0;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], i_scl};
            scl_low_r  <= scl_low_nxt;
            rst_cnt_r  <= rst_cnt_nxt;
            o_bus_rst  <= bus_rst_nxt;
        end
    end

    // Command interpreter, security state, settings and block buffer
    always_comb begin
        state_nxt    = state_r;
        cfg_nxt      = cfg_r;
        blk_nxt      = blk_r;
        ld_cnt_nxt   = ld_cnt_r;
        unlocked_nxt = unlocked_r;
        key1_nxt     = key1_r;
        sub_lo_nxt   = sub_lo_r;
        mask_nxt     = mask_r;
        rdata_nxt    = 8'h00;
        alert_set    = 8'h00;
        alert_clr    = 8'h00;
        live         = (state_r == ST_RUN) || (state_r == ST_CFGUPD);
        sub          = sub_decode({i_wdata, sub_lo_r});

        // OTP copy: data arrives one cycle after its address
        if (state_r == ST_LOAD) begin
            if (ld_cnt_r != '0) begin
                cfg_nxt[AW'(ld_cnt_r - 1'b1)] = i_otp_data;
            end
            if (int'(ld_cnt_r) == N_SET) begin
                state_nxt = ST_RUN;
                alert_set[AL_LOADED] = 1'b1;
            end else begin
                ld_cnt_nxt = ld_cnt_r + 1'b1;
            end
        end

        // Reads return one cycle later; unmapped reads give zero
        if (i_rd) begin
            unique case (i_addr)
                CMD_STATUS: begin
                    rdata_nxt[ST_UNLOCKED] = unlocked_r;
                    rdata_nxt[ST_CFG]      = (state_r == ST_CFGUPD);
                    rdata_nxt[ST_LOADING]  = (state_r == ST_LOAD);
                    rdata_nxt[ST_RUNNING]  = (state_r == ST_RUN);
                end
                CMD_ALERT:      rdata_nxt = alert_r;
                CMD_ALERT_MASK: rdata_nxt = mask_r;
                CMD_SUB_LO:     rdata_nxt = sub_lo_r;
                default: begin
                    if (is_blk(i_addr)) begin
                        rdata_nxt = blk_r[AW'(i_addr - CMD_BLOCK)];
                    end
                end
            endcase
        end

        // Writes are taken only while the settings are loaded
        if (i_wr && live) begin
            unique case (i_addr)
                CMD_ALERT:      alert_clr = i_wdata;
                CMD_ALERT_MASK: mask_nxt = i_wdata;
                CMD_SUB_LO:     sub_lo_nxt = i_wdata;
                CMD_SUB_HI: begin
                    key1_nxt = 1'b0;
                    unique case (sub)
                        SUB_KEY1: key1_nxt = !unlocked_r;
                        SUB_KEY2: begin
                            if (key1_r && !unlocked_r) begin
                                unlocked_nxt = 1'b1;
                                alert_set[AL_UNLOCK] = 1'b1;
                            end
                        end
                        SUB_LOCK: begin
                            if (state_r == ST_RUN) begin
                                unlocked_nxt = 1'b0;
                            end
                        end
                        SUB_CFG_ENTER: begin
                            if (unlocked_r && state_r == ST_RUN) begin
                                state_nxt = ST_CFGUPD;
                                alert_set[AL_CFG_IN] = 1'b1;
                            end else if (!unlocked_r) begin
                                alert_set[AL_REJECT] = 1'b1;
                            end
                        end
                        SUB_CFG_EXIT: begin
                            if (state_r == ST_CFGUPD) begin
                                state_nxt = ST_RUN;
                                alert_set[AL_CFG_OUT] = 1'b1;
                            end
                        end
                        SUB_BLK_READ: blk_nxt = cfg_r;
                        SUB_BLK_WRITE: begin
                            if (!unlocked_r) begin
                                alert_set[AL_REJECT] = 1'b1;
                            end else begin
                                for (int i = 0; i < N_SET; i++) begin
                                    if (state_r == ST_CFGUPD ||
                                        i < RUNTIME_SET) begin
                                        cfg_nxt[i] = blk_r[i];
                                    end
                                end
                            end
                        end
                        SUB_NONE: ;
                    endcase
                end
                default: begin
                    if (is_blk(i_addr)) begin
                        blk_nxt[AW'(i_addr - CMD_BLOCK)] = i_wdata;
                    end
                end
            endcase
        end

        // Bus interface reset drops partial subcommand and key progress
        if (o_bus_rst) begin
            sub_lo_nxt = 8'h00;
            key1_nxt   = 1'b0;
            alert_set[AL_BUS_RST] = 1'b1;
        end

        // Shutdown wipes state, keys, settings, buffer and alerts; setting outputs hold; wake reloads
        if (i_pwr_mode == PM_SHUTDOWN) begin
            state_nxt    = ST_OFF;
            unlocked_nxt = 1'b0;
            key1_nxt     = 1'b0;
            sub_lo_nxt   = 8'h00;
            mask_nxt     = ALERT_MASK_RST;
            ld_cnt_nxt   = '0;
            for (int i = 0; i < N_SET; i++) begin
                cfg_nxt[i] = 8'h00;
                blk_nxt[i] = 8'h00;
            end
        end else if (state_r == ST_OFF) begin
            state_nxt  = ST_LOAD;
            ld_cnt_nxt = '0;
        end

        // Sticky events: a set in the clearing cycle wins
        alert_nxt = (alert_r & ~alert_clr) | alert_set;
        if (i_pwr_mode == PM_SHUTDOWN) begin
            alert_nxt = 8'h00;
        end

        // Settings drive the block whenever the next state is running, except out-of-range regulator codes; held in rewrite mode
        reg_sel_nxt = o_reg_sel;
        prot_nxt    = o_prot_host;
        osc_nxt     = o_osc_low_speed;
        if (state_nxt == ST_RUN) begin
            if (cfg_nxt[SET_REG_IDX][2:0] <= REG_SEL_MAX) begin
                reg_sel_nxt = cfg_nxt[SET_REG_IDX][2:0];
            end
            prot_nxt = cfg_nxt[SET_PROT_IDX];
            osc_nxt  = cfg_nxt[SET_OSC_IDX][0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r         <= ST_LOAD;
            ld_cnt_r        <= '0;
            unlocked_r      <= 1'b0;
            key1_r          <= 1'b0;
            sub_lo_r        <= 8'h00;
            alert_r         <= 8'h00;
            mask_r          <= ALERT_MASK_RST;
            o_rdata         <= 8'h00;
            o_otp_addr      <= '0;
            o_otp_rd        <= 1'b1;
            o_alert_n       <= 1'b1;
            o_unlocked      <= 1'b0;
            o_cfg_update    <= 1'b0;
            o_running       <= 1'b0;
            o_reg_sel       <= REG_SEL_RST;
            o_prot_host     <= 8'h00;
            o_osc_low_speed <= 1'b0;
            for (int i = 0; i < N_SET; i++) begin
                cfg_r[i] <= 8'h00;
                blk_r[i] <= 8'h00;
            end
        end else begin
            state_r         <= state_nxt;
            ld_cnt_r        <= ld_cnt_nxt;
            unlocked_r      <= unlocked_nxt;
            key1_r          <= key1_nxt;
            sub_lo_r        <= sub_lo_nxt;
            alert_r         <= alert_nxt;
            mask_r          <= mask_nxt;
            cfg_r           <= cfg_nxt;
            blk_r           <= blk_nxt;
            o_rdata         <= rdata_nxt;
            o_otp_addr      <= AW'(ld_cnt_nxt);
            o_otp_rd        <= (state_nxt == ST_LOAD);
            o_alert_n       <= ~|(alert_nxt & mask_nxt);
            o_unlocked      <= unlocked_nxt;
            o_cfg_update    <= (state_nxt == ST_CFGUPD);
            o_running       <= (state_nxt == ST_RUN);
            o_reg_sel       <= reg_sel_nxt;
            o_prot_host     <= prot_nxt;
            o_osc_low_speed <= osc_nxt;
        end
    end

    // Checks
    property p_cfg_needs_unlock;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_r == ST_CFGUPD) |-> unlocked_r;
    endproperty
    a_cfg_needs_unlock: assert property (p_cfg_needs_unlock)
        else $error("rewrite mode while locked");

    property p_locked_entry_ignored;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == CMD_SUB_HI && {i_wdata, sub_lo_r} == SC_CFG_ENTER
         && !unlocked_r && state_r == ST_RUN && i_pwr_mode != PM_SHUTDOWN)
        |=> (state_r == ST_RUN) && $stable(o_reg_sel);
    endproperty
    a_locked_entry_ignored: assert property (p_locked_entry_ignored)
        else $error("locked rewrite entry not ignored");

    property p_locked_blk_write;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == CMD_SUB_HI && {i_wdata, sub_lo_r} == SC_BLK_WRITE
         && !unlocked_r && state_r == ST_RUN && i_pwr_mode != PM_SHUTDOWN)
        |=> $stable(cfg_r[0]) && alert_r[AL_REJECT];
    endproperty
    a_locked_blk_write: assert property (p_locked_blk_write)
        else $error("locked settings write accepted");

    property p_unlock_keys;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == CMD_SUB_HI && {i_wdata, sub_lo_r} == KEY2
         && key1_r && state_r == ST_RUN && i_pwr_mode != PM_SHUTDOWN)
        |=> unlocked_r ##0 o_unlocked;
    endproperty
    a_unlock_keys: assert property (p_unlock_keys)
        else $error("correct keys did not unlock");

    property p_shutdown_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_pwr_mode == PM_SHUTDOWN) |=>
            (state_r == ST_OFF) && (cfg_r[0] == 8'h00) && !unlocked_r;
    endproperty
    a_shutdown_clear: assert property (p_shutdown_clear)
        else $error("shutdown did not clear registers");

    property p_load_done;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_r == ST_LOAD && int'(ld_cnt_r) == N_SET
         && i_pwr_mode != PM_SHUTDOWN)
        |=> (state_r == ST_RUN) && !unlocked_r;
    endproperty
    a_load_done: assert property (p_load_done)
        else $error("load did not end in locked running state");

    property p_lowpower_keep;
        @(posedge i_clk) disable iff (!i_rst_n)
        ((i_pwr_mode == PM_SLEEP || i_pwr_mode == PM_DEEP)
         && state_r == ST_RUN && !i_wr)
        |=> $stable(cfg_r[0]) && $stable(unlocked_r);
    endproperty
    a_lowpower_keep: assert property (p_lowpower_keep)
        else $error("registers changed in low power mode");

    property p_running_flag;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_running == (state_r == ST_RUN);
    endproperty
    a_running_flag: assert property (p_running_flag)
        else $error("running flag disagrees with state");

    property p_bus_rst;
        @(posedge i_clk) disable iff (!i_rst_n)
        (scl_low_r && rst_cnt_r == BUS_RST_CNT_W'(BUS_RST_LIM - 1))
        |=> o_bus_rst ##1 !o_bus_rst;
    endproperty
    a_bus_rst: assert property (p_bus_rst)
        else $error("bus reset pulse wrong");

    property p_reg_sel_range;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_reg_sel <= REG_SEL_MAX;
    endproperty
    a_reg_sel_range: assert property (p_reg_sel_range)
        else $error("regulator select out of range");

    property p_status_read;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == CMD_STATUS)
        |=> o_rdata[ST_UNLOCKED] == $past(unlocked_r);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read data wrong");

    property p_alert_pin;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_alert_n == !(|(alert_r & mask_r));
    endproperty
    a_alert_pin: assert property (p_alert_pin)
        else $error("alert pin disagrees with status");
endmodule
`default_nettype wire

// ==== tb/otp_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module otp_model #(
    parameter int AW = 4
) (
    input  wire logic          i_clk,
    input  wire logic          i_rd,
    input  wire logic [AW-1:0] i_addr,
    output var  logic [7:0]    o_data
);
    // Stored byte for each setting index
    function automatic logic [7:0] rom(input logic [AW-1:0] a);
        case (a)
            0:       rom = 8'h03;
            1:       rom = 8'h5A;
            2:       rom = 8'h01;
            default: rom = 8'hC0 ^ 8'(a);
        endcase
    endfunction
    initial o_data = 8'h00;
    // Byte follows the address one cycle later; scrambled when idle
    always_ff @(posedge i_clk) begin
        o_data <= i_rd ? rom(i_addr) : ~o_data;
    end
endmodule
`default_nettype wire

// ==== tb/host_command_security_config_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_command_security_config_test;
    import hcsc_pkg::*;
    typedef struct {logic [15:0] code; logic [7:0] st;} row_t;
    logic       clk = 0, rst_n = 0, wr = 0, rd = 0, scl = 1;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00, rdata, otp_data, prot_host;
    logic [1:0] pwr_mode = PM_NORMAL;
    logic [3:0] otp_addr;
    logic [2:0] reg_sel;
    logic       otp_rd, alert_n, unlocked, cfg_update, running;
    logic       osc_low, bus_rst;
    int         miscompares = 0, samples_checked = 0, n;
    row_t rows [10] = '{'{SC_CFG_ENTER, 8'h08}, '{SC_BLK_WRITE, 8'h08},
        '{16'h1A2B, 8'h08}, '{SC_BLK_READ, 8'h08}, '{16'h3C4D, 8'h08},
        '{16'h1A2B, 8'h08}, '{16'h3C4D, 8'h09}, '{SC_CFG_ENTER, 8'h03},
        '{SC_CFG_EXIT, 8'h09}, '{SC_LOCK, 8'h08}};

    host_command_security_config #(.N_SET(16), .RUNTIME_SET(4),
        .BUS_RST_LIM(50)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_pwr_mode(pwr_mode), .i_scl(scl),
        .i_otp_data(otp_data), .o_otp_addr(otp_addr), .o_otp_rd(otp_rd),
        .o_alert_n(alert_n), .o_unlocked(unlocked),
        .o_cfg_update(cfg_update), .o_running(running),
        .o_reg_sel(reg_sel), .o_prot_host(prot_host),
        .o_osc_low_speed(osc_low), .o_bus_rst(bus_rst));
    otp_model #(.AW(4)) otp_u (.i_clk(clk), .i_rd(otp_rd),
        .i_addr(otp_addr), .o_data(otp_data));

    // Clock, 50 ns period
    initial forever #25 clk = ~clk;

    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wrt(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    // Read data is looked at in the single cycle after the strobe
    task automatic rdc(input logic [6:0] a, input logic [7:0] e,
                       input string nm);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1;
        chk(nm, e, rdata);
    endtask
    task automatic sub(input logic [15:0] c);
        wrt(CMD_SUB_LO, c[7:0]);
        wrt(CMD_SUB_HI, c[15:8]);
    endtask
    task automatic wait_run();
        n = 0;
        while (running !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk("running", 8'h01, {7'h00, running});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        final_report();
    end

    initial begin
        tick(20);
        chk("otp_rd", 8'h01, {7'h00, otp_rd});
        chk("unlocked", 8'h00, {7'h00, unlocked});
        rst_n <= 1;
        wait_run();
        chk("reg_sel", 8'h03, {5'h00, reg_sel});
        chk("prot", 8'h5A, prot_host);
        chk("osc", 8'h01, {7'h00, osc_low});
        rdc(CMD_STATUS, 8'h08, "status");
        rdc(CMD_ALERT_MASK, 8'hFF, "mask");
        rdc(CMD_ALERT, 8'h20, "alert");
        chk("alert_n", 8'h00, {7'h00, alert_n});
        rdc(7'h7F, 8'h00, "unmapped");
        $display("test reset done");
        // Security sequence table
        foreach (rows[i]) begin
            sub(rows[i].code);
            rdc(CMD_STATUS, rows[i].st, "status");
            chk("unlocked", {7'h00, rows[i].st[0]}, {7'h00, unlocked});
            chk("cfg", {7'h00, rows[i].st[1]}, {7'h00, cfg_update});
            chk("reg_sel", 8'h03, {5'h00, reg_sel});
        end
        $display("test table done");
        // Full rewrite of settings halts operation until exit
        sub(16'h1A2B);
        sub(16'h3C4D);
        sub(SC_CFG_ENTER);
        wrt(CMD_BLOCK, 8'h04);
        wrt(CMD_BLOCK + 7'h01, 8'h0F);
        wrt(CMD_BLOCK + 7'h02, 8'h00);
        rdc(CMD_BLOCK + 7'h01, 8'h0F, "block");
        sub(SC_BLK_WRITE);
        tick(2);
        chk("running", 8'h00, {7'h00, running});
        chk("reg_sel", 8'h03, {5'h00, reg_sel});
        sub(SC_CFG_EXIT);
        tick(2);
        chk("reg_sel", 8'h04, {5'h00, reg_sel});
        chk("prot", 8'h0F, prot_host);
        chk("osc", 8'h00, {7'h00, osc_low});
        // Run-time change of a selected setting, bad code ignored
        wrt(CMD_BLOCK, 8'h02);
        sub(SC_BLK_WRITE);
        tick(2);
        chk("reg_sel", 8'h02, {5'h00, reg_sel});
        wrt(CMD_BLOCK, 8'h07);
        sub(SC_BLK_WRITE);
        tick(2);
        chk("reg_sel", 8'h02, {5'h00, reg_sel});
        $display("test rewrite done");
        // Low-power modes keep state, shutdown clears and reloads
        pwr_mode <= PM_SLEEP;
        tick(3);
        pwr_mode <= PM_DEEP;
        tick(3);
        pwr_mode <= PM_NORMAL;
        tick(2);
        chk("reg_sel", 8'h02, {5'h00, reg_sel});
        chk("unlocked", 8'h01, {7'h00, unlocked});
        pwr_mode <= PM_SHUTDOWN;
        tick(3);
        pwr_mode <= PM_NORMAL;
        tick(1);
        chk("unlocked", 8'h00, {7'h00, unlocked});
        wait_run();
        chk("reg_sel", 8'h03, {5'h00, reg_sel});
        $display("test power done");
        // Serial clock held low resets the bus
        scl <= 0;
        n = 0;
        while (bus_rst !== 1'b1 && n < 70) begin
            tick(1);
            n++;
        end
        scl <= 1;
        chk("bus_rst", 8'h01, {7'h00, bus_rst});
        rdc(CMD_ALERT, 8'h30, "alert");
        wrt(CMD_ALERT_MASK, 8'h00);
        tick(2);
        chk("alert_n", 8'h01, {7'h00, alert_n});
        wrt(CMD_ALERT_MASK, 8'hFF);
        tick(2);
        chk("alert_n", 8'h00, {7'h00, alert_n});
        wrt(CMD_ALERT, 8'hFF);
        tick(2);
        chk("alert_n", 8'h01, {7'h00, alert_n});
        $display("test alert done");
        // Reset in mid-run drops the unlock and reloads settings
        sub(16'h1A2B);
        sub(16'h3C4D);
        rst_n <= 0;
        tick(2);
        chk("otp_addr", 8'h00, {4'h0, otp_addr});
        chk("running", 8'h00, {7'h00, running});
        chk("reg_sel", 8'h00, {5'h00, reg_sel});
        chk("unlocked", 8'h00, {7'h00, unlocked});
        rst_n <= 1;
        wait_run();
        rdc(CMD_STATUS, 8'h08, "status");
        chk("reg_sel", 8'h03, {5'h00, reg_sel});
        $display("test mid reset done");
        final_report();
    end
endmodule
`default_nettype wire
